// file: rtl/i2c_flags_defs.svh
// Purpose: Offsets, bit positions, reset values and codes of the flag block.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef I2C_FLAGS_DEFS_SVH
`define I2C_FLAGS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CTRL_OFS        8'h00
`define SADDR_OFS       8'h04
`define STATUS_OFS      8'h08
`define IRQ_STAT_OFS    8'h0c
`define IRQ_CLR_OFS     8'h10
`define IRQ_EN_OFS      8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT 7
`define CTRL_EXIT_BIT   6
`define CTRL_WREL_BIT   5
`define ST_ARB_BIT      6
`define ST_EXT_BIT      5
`define ST_MATCH_BIT    4
`define ST_DIR_BIT      3
`define EV_START_BIT    0
`define EV_STOP_BIT     1
`define EV_EXT_BIT      2
`define EV_MATCH_BIT    3
`define EV_BYTE_BIT     4

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define STATUS_RESET    8'h00
`define SADDR_RESET     7'h00
`define IRQ_RESET       5'h00
`define DATA_RESET      32'h0000_0000
`define EXT_CODE_LOW    4'h0
`define EXT_CODE_HIGH   4'hf
`define ADDR_LAST_CNT   4'h7
`define ACK_CLK_CNT     4'h9
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// file: rtl/i2c_flags_pkg.sv
// Purpose: Types shared by the flag block.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only.
package i2c_flags_pkg;

	typedef enum logic [1:0] {
		phase_idle,
		phase_first_byte,
		phase_data
	} bus_phase_t;

	typedef logic [7:0] byte_reg_t;

endpackage : i2c_flags_pkg

// file: rtl/pin_edge_sync.sv
// Purpose: Two-stage synchroniser for a pin with edge detection.
// Assumes: The pin is asynchronous to sys_clk_i.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync (
	input  wire logic sys_clk_i, // System clock.
	input  wire logic rst_i,     // Synchronous reset, active high.
	input  wire logic pin_i,     // Asynchronous pin level.
	output var  logic level_o,   // Synchronised level.
	output var  logic rise_o,    // One-cycle pulse on a rising edge.
	output var  logic fall_o     // One-cycle pulse on a falling edge.
);

	logic meta;
	logic stable;
	logic delayed;

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			meta    <= 1'b1;
			stable  <= 1'b1;
			delayed <= 1'b1;
		end
		else
		begin
			meta    <= pin_i;
			stable  <= meta;
			delayed <= stable;
		end
	end

	assign level_o = delayed;
	assign rise_o  = stable & ~delayed;
	assign fall_o  = ~stable & delayed;

endmodule : pin_edge_sync

`default_nettype wire

// file: rtl/i2c_addr_dir_status_flags.sv
// Purpose: Extension-code, address-match and direction flags of an I2C
//          interface, with an AXI4-Lite register port and an interrupt.
// Assumes: SCL and SDA are asynchronous pins; master role, start
//          generation, serial output latch, wait and arbitration loss
//          come from neighbouring logic on sys_clk_i.
// Notes:   Extension, match and direction flag clears win over sets in the same cycle; interrupt status sets win over clears.
//
// How it works
// R1: Extension flag sets at eighth clock rise on upper nibble 0000 or 1111.
// R2: Extension flag clears on start, stop, exit request, enable fall, reset.
// R3: Match flag sets at eighth clock rise when address equals local address.
// R4: Match flag clears on start, stop, exit request, enable fall, reset.
// R5: Receive direction keeps the data line driver floating.
// R6: Transmit direction drives latch from ninth clock fall of first byte.
// R7: Master sets direction on start generation or direction bit 0 output.
// R8: Slave sets direction when direction bit 1 is received.
// R9: Direction clears on stop, exit, disable, wait release, arb loss, reset.
// R10: Master clears direction when it outputs direction bit 1.
// R11: Slave clears direction on start or received direction bit 0.
// R12: Wait release at ninth clock with direction set clears it, floats line.
// R13: Status read clears arbitration loss flag; software reads it first.
// R14: Exit request is control bit 6, interface enable is control bit 7.
// R15: Status read-only, readable when busy or waiting, reset to zero.
// R16: Bus events synchronised to system clock; clear beats set.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_flags_defs.svh"

module i2c_addr_dir_status_flags
	import i2c_flags_pkg::*;
#(
	parameter int SADDR_W = 7
) (
	input  wire logic        sys_clk_i,     // System clock, 50 MHz.
	input  wire logic        rst_i,         // Synchronous reset, high.
	input  wire logic        scl_i,         // Serial clock pin level.
	input  wire logic        sda_i,         // Serial data pin level.
	output var  logic        sda_o,         // Data pin output value.
	output var  logic        sda_oe_n_o,    // Data pin drive, low drives.
	input  wire logic        master_i,      // Device acts as master.
	input  wire logic        start_gen_i,   // Pulse: start generated.
	input  wire logic        so_latch_i,    // Serial output latch bit.
	input  wire logic        wait_i,        // Bus is in wait period.
	input  wire logic        arb_lost_i,    // Arbitration-loss flag.
	output var  logic        arb_clear_o,   // Pulse: clear arb flag.
	output var  logic        irq_o,         // Level interrupt.
	input  wire logic [7:0]  awaddr_i,      // Write address.
	input  wire logic        awvalid_i,     // Write address valid.
	output var  logic        awready_o,     // Write address ready.
	input  wire logic [31:0] wdata_i,       // Write data.
	input  wire logic [3:0]  wstrb_i,       // Write strobes.
	input  wire logic        wvalid_i,      // Write data valid.
	output var  logic        wready_o,      // Write data ready.
	output var  logic [1:0]  bresp_o,       // Write response.
	output var  logic        bvalid_o,      // Write response valid.
	input  wire logic        bready_i,      // Write response ready.
	input  wire logic [7:0]  araddr_i,      // Read address.
	input  wire logic        arvalid_i,     // Read address valid.
	output var  logic        arready_o,     // Read address ready.
	output var  logic [31:0] rdata_o,       // Read data.
	output var  logic [1:0]  rresp_o,       // Read response.
	output var  logic        rvalid_o,      // Read data valid.
	input  wire logic        rready_i       // Read data ready.
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic scl_lvl;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic sda_rise;
	logic sda_fall;

	pin_edge_sync u_scl_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.pin_i     (scl_i),
		.level_o   (scl_lvl),
		.rise_o    (scl_rise),
		.fall_o    (scl_fall)
	); // R16

	pin_edge_sync u_sda_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.pin_i     (sda_i),
		.level_o   (sda_lvl),
		.rise_o    (sda_rise),
		.fall_o    (sda_fall)
	); // R16

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	bus_phase_t           phase;
	logic [3:0]           bit_cnt;
	byte_reg_t            rx_byte;
	logic                 enable;
	logic [SADDR_W-1:0]   local_slave_address;
	logic                 extension_code_flag;
	logic                 address_match_flag;
	logic                 direction_flag;
	logic                 drive_armed;
	logic                 arb_prev;
	logic [4:0]           irq_status;
	logic [4:0]           irq_enable;

	// ------------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------------
	wire wr_go     = awvalid_i & wvalid_i & ~awready_o & ~bvalid_o;
	wire rd_go     = arvalid_i & ~arready_o & ~rvalid_o;
	wire wr_low    = wr_go & wstrb_i[0];
	wire wa_ctrl   = awaddr_i == `CTRL_OFS;
	wire wa_saddr  = awaddr_i == `SADDR_OFS;
	wire wa_clr    = awaddr_i == `IRQ_CLR_OFS;
	wire wa_en     = awaddr_i == `IRQ_EN_OFS;
	wire wa_ro     = (awaddr_i == `STATUS_OFS) |
	                 (awaddr_i == `IRQ_STAT_OFS);
	wire wa_hit    = wa_ctrl | wa_saddr | wa_clr | wa_en | wa_ro;
	wire wr_ctrl   = wr_low & wa_ctrl;
	wire exit_comm_request = wr_ctrl & wdata_i[`CTRL_EXIT_BIT]; // R14
	wire wait_release      = wr_ctrl & wdata_i[`CTRL_WREL_BIT];
	wire next_enable = wr_ctrl ? wdata_i[`CTRL_ENABLE_BIT] : enable; // R14
	wire enable_fall = enable & ~next_enable;
	wire [4:0] irq_clr_mask = (wr_low & wa_clr) ? wdata_i[4:0] : 5'h00;

	wire ra_ctrl   = araddr_i == `CTRL_OFS;
	wire ra_saddr  = araddr_i == `SADDR_OFS;
	wire ra_status = araddr_i == `STATUS_OFS;
	wire ra_istat  = araddr_i == `IRQ_STAT_OFS;
	wire ra_clr    = araddr_i == `IRQ_CLR_OFS;
	wire ra_en     = araddr_i == `IRQ_EN_OFS;
	wire ra_hit    = ra_ctrl | ra_saddr | ra_status | ra_istat |
	                 ra_clr | ra_en;

	// ------------------------------------------------------------------
	// Bus events
	// ------------------------------------------------------------------
	wire start_det = enable & sda_fall & scl_lvl;
	wire stop_det  = enable & sda_rise & scl_lvl;
	wire in_frame  = phase != phase_idle;
	wire first_b   = phase == phase_first_byte;
	wire addr_clk  = enable & first_b & scl_rise &
	                 (bit_cnt == `ADDR_LAST_CNT);
	wire ack_fall  = enable & in_frame & scl_fall &
	                 (bit_cnt == `ACK_CLK_CNT);
	wire [7:0] addr_byte = {rx_byte[6:0], sda_lvl};
	wire dir_bit   = addr_byte[0];
	wire arb_rise  = arb_lost_i & ~arb_prev;
	wire comm_end  = stop_det | exit_comm_request | enable_fall;

	wire ext_hit   = addr_clk &
	                 ((addr_byte[7:4] == `EXT_CODE_LOW) |
	                  (addr_byte[7:4] == `EXT_CODE_HIGH)); // R1
	wire match_hit = addr_clk &
	                 (addr_byte[7:1] == local_slave_address); // R3

	wire ext_clr   = start_det | comm_end; // R2
	wire match_clr = start_det | comm_end; // R4

	wire next_ext   = ext_clr ? 1'b0 :
	                  ext_hit ? 1'b1 : extension_code_flag; // R16
	wire next_match = match_clr ? 1'b0 :
	                  match_hit ? 1'b1 : address_match_flag; // R16

	wire dir_set_m = master_i & (start_gen_i | (addr_clk & ~dir_bit)); // R7
	wire dir_set_s = ~master_i & addr_clk & dir_bit; // R8
	wire dir_clr_m = master_i & addr_clk & dir_bit; // R10
	wire dir_clr_s = ~master_i & (start_det | (addr_clk & ~dir_bit)); // R11
	wire dir_clr   = comm_end | wait_release | arb_rise |
	                 dir_clr_m | dir_clr_s; // R9 R12
	wire next_dir  = dir_clr ? 1'b0 :
	                 (dir_set_m | dir_set_s) ? 1'b1 : direction_flag; // R16

	wire next_armed = (dir_clr | ~next_dir) ? 1'b0 :
	                  (ack_fall & first_b) ? 1'b1 : drive_armed; // R6 R12
	wire drive_low  = next_dir & next_armed & ~so_latch_i; // R5 R6

	wire [4:0] events;
	assign events[`EV_START_BIT] = start_det;
	assign events[`EV_STOP_BIT]  = stop_det;
	assign events[`EV_EXT_BIT]   = ext_hit;
	assign events[`EV_MATCH_BIT] = match_hit;
	assign events[`EV_BYTE_BIT]  = ack_fall;
	wire [4:0] next_irq_status = (irq_status & ~irq_clr_mask) | events;
	wire [4:0] next_irq_enable = (wr_low & wa_en) ? wdata_i[4:0] :
	                             irq_enable;

	// ------------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------------
	wire status_ok = in_frame | wait_i; // R15
	wire [7:0] status_byte = {1'b0, arb_lost_i, extension_code_flag,
	                          address_match_flag, direction_flag,
	                          3'b000};
	wire [31:0] rd_word =
		ra_ctrl   ? {24'h00_0000, enable, 7'h00} :
		ra_saddr  ? {{(32 - SADDR_W){1'b0}}, local_slave_address} :
		ra_status ? {24'h00_0000,
		             status_ok ? status_byte : `STATUS_RESET} :
		ra_istat  ? {27'h000_0000, irq_status} :
		ra_en     ? {27'h000_0000, irq_enable} :
		`DATA_RESET;

	// ------------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			phase   <= phase_idle;
			bit_cnt <= 4'h0;
			rx_byte <= 8'h00;
		end
		else if (stop_det | ~enable | exit_comm_request)
		begin
			phase   <= phase_idle;
			bit_cnt <= 4'h0;
		end
		else if (start_det)
		begin
			phase   <= phase_first_byte;
			bit_cnt <= 4'h0;
		end
		else if (ack_fall)
		begin
			phase   <= phase_data;
			bit_cnt <= 4'h0;
		end
		else if (scl_rise & in_frame & (bit_cnt < `ACK_CLK_CNT))
		begin
			bit_cnt <= bit_cnt + 4'h1;
			rx_byte <= addr_byte;
		end
		else
		begin
			case (phase)
				phase_idle:       bit_cnt <= 4'h0;
				phase_first_byte: bit_cnt <= bit_cnt;
				phase_data:       bit_cnt <= bit_cnt;
				default:          phase   <= phase_idle;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Flags and pin drive
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			extension_code_flag <= 1'b0; // R2
			address_match_flag  <= 1'b0; // R4
			direction_flag      <= 1'b0; // R9
			drive_armed         <= 1'b0;
			arb_prev            <= 1'b0;
			sda_o               <= 1'b0;
			sda_oe_n_o          <= 1'b1;
		end
		else
		begin
			extension_code_flag <= next_ext;
			address_match_flag  <= next_match;
			direction_flag      <= next_dir;
			drive_armed         <= next_armed;
			arb_prev            <= arb_lost_i;
			sda_o               <= 1'b0;
			sda_oe_n_o          <= ~drive_low; // R5 R6
		end
	end

	// ------------------------------------------------------------------
	// Registers and interrupt
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			enable              <= 1'b0;
			local_slave_address <= `SADDR_RESET;
			irq_status          <= `IRQ_RESET;
			irq_enable          <= `IRQ_RESET;
			irq_o               <= 1'b0;
		end
		else
		begin
			enable     <= next_enable;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq_o      <= |(next_irq_status & next_irq_enable);
			if (wr_low & wa_saddr)
				local_slave_address <= wdata_i[SADDR_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite handshakes
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			awready_o   <= 1'b0;
			wready_o    <= 1'b0;
			bvalid_o    <= 1'b0;
			bresp_o     <= `RESP_OKAY;
			arready_o   <= 1'b0;
			rvalid_o    <= 1'b0;
			rresp_o     <= `RESP_OKAY;
			rdata_o     <= `DATA_RESET;
			arb_clear_o <= 1'b0;
		end
		else
		begin
			awready_o   <= wr_go;
			wready_o    <= wr_go;
			arready_o   <= rd_go;
			arb_clear_o <= rd_go & ra_status & status_ok; // R13
			if (wr_go)
			begin
				bvalid_o <= 1'b1;
				bresp_o  <= wa_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (bready_i)
				bvalid_o <= 1'b0;
			if (rd_go)
			begin
				rvalid_o <= 1'b1;
				rdata_o  <= rd_word;
				rresp_o  <= ra_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (rready_i)
				rvalid_o <= 1'b0;
		end
	end

endmodule : i2c_addr_dir_status_flags

`default_nettype wire

// file: bench/i2c_flags_props.sv
// Purpose: Port checks for the flag block.
// Assumes: One clock domain, synchronous reset.
// Notes:   Bound to the design top.
`timescale 1ns/100ps
`default_nettype none

module i2c_flags_props #(
	parameter int SADDR_W = 7
) (
	input wire logic        sys_clk_i,  // Clock.
	input wire logic        rst_i,      // Reset.
	input wire logic        so_latch_i, // Output latch.
	input wire logic        sda_o,      // Pin value.
	input wire logic        sda_oe_n_o, // Pin drive.
	input wire logic        arb_clear_o, // Arb clear.
	input wire logic        irq_o,      // Interrupt.
	input wire logic        awvalid_i,  // Bus.
	input wire logic        wvalid_i,   // Bus.
	input wire logic        awready_o,  // Bus.
	input wire logic        wready_o,   // Bus.
	input wire logic        bvalid_o,   // Bus.
	input wire logic        bready_i,   // Bus.
	input wire logic [1:0]  bresp_o,    // Bus.
	input wire logic        arvalid_i,  // Bus.
	input wire logic        arready_o,  // Bus.
	input wire logic        rvalid_o,   // Bus.
	input wire logic        rready_i,   // Bus.
	input wire logic [31:0] rdata_o     // Bus.
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !irq_o && sda_oe_n_o && !rvalid_o && !bvalid_o)
		else $error("outputs not quiet after reset");
	a_write_answer: assert property (awvalid_i && wvalid_i
		&& !awready_o && !bvalid_o |=> awready_o && wready_o && bvalid_o)
		else $error("write not answered in one cycle");
	a_bvalid_stands: assert property (bvalid_o && !bready_i
		|=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped");
	a_read_answer: assert property (arvalid_i && !arready_o
		&& !rvalid_o |=> arready_o && rvalid_o)
		else $error("read not answered in one cycle");
	a_rvalid_stands: assert property (rvalid_o && !rready_i
		|=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped");
	a_rdata_byte: assert property (rvalid_o |-> rdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_drive_latch: assert property (!sda_oe_n_o
		|-> !sda_o && !$past(so_latch_i))
		else $error("data line driven against latch");
	a_arb_pulse: assert property (arb_clear_o |=> !arb_clear_o)
		else $error("arb clear longer than one cycle");
	a_ready_pulse: assert property (arready_o |=> !arready_o)
		else $error("read ready longer than one cycle");
endmodule : i2c_flags_props

bind i2c_addr_dir_status_flags i2c_flags_props #(.SADDR_W(SADDR_W)) u_props (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .so_latch_i(so_latch_i),
	.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .arb_clear_o(arb_clear_o),
	.irq_o(irq_o), .awvalid_i(awvalid_i), .wvalid_i(wvalid_i),
	.awready_o(awready_o), .wready_o(wready_o), .bvalid_o(bvalid_o),
	.bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i),
	.arready_o(arready_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
	.rdata_o(rdata_o));

`default_nettype wire

// file: bench/i2c_far_master_model.sv
// Purpose: Behavioural far-side master on a pulled-up I2C bus.
// Assumes: Link clock period 160 ns, clock idles high between frames.
// Notes:   Pulls the data line low only; release means pull-up.
`timescale 1ns/100ps
`default_nettype none

module i2c_far_master_model (
	output var logic scl_o,     // Serial clock level.
	output var logic sda_low_o  // High pulls data low.
);
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic start_c();
		#7 sda_low_o = 1'b1;
		#80 scl_o = 1'b0;
	endtask : start_c

	// Data changes only while the clock is low.
	task automatic send_bit(input logic b);
		#20 sda_low_o = !b;
		#60 scl_o = 1'b1;
		#80 scl_o = 1'b0;
	endtask : send_bit

	task automatic send(input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			send_bit(d[i]);
	endtask : send

	task automatic stop_c();
		#20 sda_low_o = 1'b1;
		#60 scl_o = 1'b1;
		#80 sda_low_o = 1'b0;
		#80;
	endtask : stop_c
endmodule : i2c_far_master_model

`default_nettype wire

// file: bench/test_i2c_addr_dir_status_flags.sv
// Purpose: Register and bus scenarios for the flag block.
// Assumes: Far side is a behavioural master on a pulled-up line.
// Notes:   Status readability comes from frame or wait.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_flags_defs.svh"

module test_i2c_addr_dir_status_flags;
	logic        sys_clk = 0, rst = 1, scl, far_low, sda_o, oe_n;
	logic        master = 0, start_gen = 0, so_latch = 0, wait_s = 0;
	logic        arb = 0, arb_clr, irq, awready, wready, bvalid, arready;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic        rready = 0, rvalid;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp;
	int          fail_count = 0, samples_checked = 0;
	logic        arb_seen = 0;
	wire         sda_line = !(far_low || (!oe_n && !sda_o));

	always #10 sys_clk = ~sys_clk;

	// Remembers that the arbitration clear pulse was seen at all.
	always @(posedge sys_clk)
		if (arb_clr === 1'b1)
			arb_seen <= 1'b1;

	i2c_far_master_model far (.scl_o(scl), .sda_low_o(far_low));

	i2c_addr_dir_status_flags dut (
		.sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_n_o(oe_n), .master_i(master),
		.start_gen_i(start_gen), .so_latch_i(so_latch), .wait_i(wait_s),
		.arb_lost_i(arb), .arb_clear_o(arb_clr), .irq_o(irq),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
		.wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
		.wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
		.bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
		.rvalid_o(rvalid), .rready_i(rready));

	task automatic close_out();
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// The answer is sampled at the edge after the one that takes the request.
	task automatic await(ref logic s);
		int n;
		for (n = 0; n < 50 && s !== 1'b1; n++)
			@(posedge sys_clk);
		if (n == 50)
		begin
			fail_count++;
			$display("FAIL t=%0t bus answer timed out", $time);
			close_out();
		end
	endtask : await

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		await(bvalid);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b0;
		chk({32'h0, bresp},
		    {32'h0, (a > 8'h14 ? `RESP_SLVERR : `RESP_OKAY)});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		await(rvalid);
		arvalid <= 1'b0;
		rready <= 1'b0;
		chk({rresp, rdata}, {(a > 8'h14 ? `RESP_SLVERR : `RESP_OKAY), e});
	endtask : rd

	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask : settle

	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`STATUS_OFS, 32'h0);
		rd(8'h3c, 32'h0);
		wr(8'h3c, 32'h1);
		wr(`SADDR_OFS, 32'h5a);
		wr(`CTRL_OFS, 32'h80);
		rd(`CTRL_OFS, 32'h80);
		far.start_c();
		far.send(8'hb5);
		settle();
		rd(`STATUS_OFS, 32'h18);
		far.send_bit(1'b1);
		settle();
		chk(oe_n, 0);
		so_latch <= 1'b1;
		settle();
		chk(oe_n, 1);
		so_latch <= 1'b0;
		wr(`CTRL_OFS, 32'ha0);
		settle();
		chk(oe_n, 1);
		rd(`STATUS_OFS, 32'h10);
		far.stop_c();
		settle();
		chk(irq, 0);
		wait_s <= 1'b1;
		rd(`STATUS_OFS, 32'h0);
		wait_s <= 1'b0;
		wr(`IRQ_EN_OFS, 32'h1f);
		settle();
		chk(irq, 1);
		rd(`IRQ_STAT_OFS, 32'h1b);
		wr(`IRQ_CLR_OFS, 32'h1b);
		settle();
		chk(irq, 0);
		far.start_c();
		far.send(8'hf0);
		settle();
		rd(`STATUS_OFS, 32'h20);
		wait_s <= 1'b1;
		wr(`CTRL_OFS, 32'hc0);
		rd(`STATUS_OFS, 32'h0);
		far.stop_c();
		far.start_c();
		far.send(8'h01);
		settle();
		rd(`STATUS_OFS, 32'h28);
		arb <= 1'b1;
		settle();
		rd(`STATUS_OFS, 32'h60);
		wr(`CTRL_OFS, 32'h00);
		wait_s <= 1'b1;
		rd(`STATUS_OFS, 32'h40);
		arb <= 1'b0;
		far.stop_c();
		wr(`CTRL_OFS, 32'h80);
		master <= 1'b1;
		@(posedge sys_clk);
		start_gen <= 1'b1;
		@(posedge sys_clk);
		start_gen <= 1'b0;
		rd(`STATUS_OFS, 32'h08);
		wr(`CTRL_OFS, 32'hc0);
		rd(`STATUS_OFS, 32'h0);
		@(posedge sys_clk);
		start_gen <= 1'b1;
		@(posedge sys_clk);
		start_gen <= 1'b0;
		far.start_c();
		far.send(8'h01);
		settle();
		rd(`STATUS_OFS, 32'h20);
		far.stop_c();
		far.start_c();
		far.send(8'hb4);
		settle();
		rd(`STATUS_OFS, 32'h18);
		far.stop_c();
		chk({33'h0, arb_seen}, {33'h0, 1'b1});
		close_out();
	end
endmodule : test_i2c_addr_dir_status_flags

`default_nettype wire
